// ### core/nidrb_register_bank.v
// Operation
// - Probe register is 8-bit read/write, zero on hardware reset, kept on soft reset.
// - A seen node matching the probe register sets the probe-found diagnostic flag.
// - The own token successor is never reported as found by probing.
// - Core stays asleep while the own identifier is zero.
// - Nonzero own identifier wakes core; ring joining waits for transmit-join enable.
// - Own identifier register is 8-bit read/write, zero on hardware reset only.
// - Successor register is read-only, updated by the core on ring changes.
// - Successor update sets new-successor flag; reading the successor clears it.
// - Successor register clears on hardware or soft reset.
// - Main status is read-only and reads 1001_0001 after any reset.
// - Main status shows alternate bits while command chaining is enabled.
// - Extended timeout bits live in the configuration register, not status.
// - Diagnostic flags clear on read or reset, except excess-NAK and new-successor.
// - Excess-NAK clears only by power-flag-clear command or any reset.
// - Diagnostic register reads zero after any reset, bit zero reads zero.
// - Pointer high written first; writing the low byte loads the combined pointer.
// - Configuration is read/write, 18h on hardware reset, low bits select indirect.
// - Sub-address bits 2..0 select indirect register; bits 1..0 shared with config.
// - Sub-address bit two selects second setup; a config write clears it.
// - First setup holds rate scaler, slow arbitration, receive-all and pulse type.
// - First setup is 8-bit read/write, zero on hardware reset only.
// - Maskable flags are ANDed with mask bits and ORed onto one interrupt.
// - A low pointer write starts one RAM read into the data register only when pointer-high bit 7 is set.
`timescale 1ns/10ps
`include "nidrb_consts.vh"

module nidrb_register_bank
(
    input wire clk_in,
    input wire nrst_in,
    input wire cs_n_in,
    input wire rd_n_in,
    input wire wr_n_in,
    input wire [2:0] addr_in,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output wire data_oe_out,
    input wire succ_update_in,
    input wire [7:0] succ_value_in,
    input wire node_seen_in,
    input wire [7:0] node_seen_id_in,
    input wire myrecon_event_in,
    input wire duplicate_node_flag_in,
    input wire rcvact_event_in,
    input wire token_event_in,
    input wire excess_nak_event_in,
    input wire recon_event_in,
    input wire clear_flags_in,
    input wire por_clear_flags_in,
    input wire ri_in,
    input wire ta_in,
    input wire tma_in,
    input wire [7:0] chain_status_in,
    input wire [7:0] ram_rdata_in,
    input wire ram_rvalid_in,
    output reg command_strobe_out,
    output reg [7:0] command_code_out,
    output reg [10:0] ram_addr_out,
    output reg ram_rd_out,
    output reg ram_wr_out,
    output reg [7:0] ram_wdata_out,
    output wire core_awake_out,
    output wire transmit_join_enable_out,
    output wire receiver_on_out,
    output wire soft_reset_out,
    output wire chain_enable_out,
    output wire [1:0] ext_timeout_out,
    output wire backplane_out,
    output wire [7:0] speed_setup_out,
    output wire [7:0] second_setup_out,
    output wire [7:0] test_setup_out,
    output wire interrupt_out
);

    // ------------------------------------------------------------
    // Reset and pin synchronisers
    // ------------------------------------------------------------
    reg rst_meta_r;
    reg rst_n_r;
    reg [12:0] pin_meta_r;
    reg [12:0] pin_r;
    reg [7:0] din_meta_r;
    reg [7:0] din_r;
    reg wr_act_d_r;
    reg rd_act_d_r;

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    wire wr_act = !pin_r[12] && !pin_r[10];
    wire rd_act = !pin_r[12] && !pin_r[11];

    // Address, data and strobes all come from a foreign bus, so every one of them
    // is double sampled; the host must hold address and data stable around strobes.
    always @(posedge clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pin_meta_r <= 13'h1fff;
            pin_r <= 13'h1fff;
            din_meta_r <= 8'h00;
            din_r <= 8'h00;
            wr_act_d_r <= 1'b0;
            rd_act_d_r <= 1'b0;
        end
        else
        begin
            pin_meta_r <= {cs_n_in, rd_n_in, wr_n_in, addr_in, 7'h00};
            pin_r <= pin_meta_r;
            din_meta_r <= data_in;
            din_r <= din_meta_r;
            wr_act_d_r <= wr_act;
            rd_act_d_r <= rd_act;
        end
    end

    wire [2:0] addr_s = pin_r[9:7];
    wire wr_go = wr_act && !wr_act_d_r;
    wire rd_go = rd_act && !rd_act_d_r;

    assign data_oe_out = rd_act;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg [7:0] probe_node_register_r;
    reg [7:0] own_node_number_r;
    reg [7:0] successor_node_number_r;
    reg [7:0] mode_configuration_r;
    reg [7:0] speed_setup_r;
    reg [7:0] second_setup_r;
    reg [7:0] test_setup_r;
    reg [7:0] interrupt_mask_r;
    reg [7:0] ram_pointer_high_r;
    reg [7:0] ram_pointer_low_r;
    reg [7:0] data_r;
    reg select_bit_two_r;
    reg [1:0] subsel_spare_r;
    reg por_r;
    reg recon_r;
    reg ri_r;
    reg ta_r;
    reg tma_r;
    reg [7:0] diag_r;

    wire soft_rst = mode_configuration_r[`NIDRB_CFG_RESET];
    wire [2:0] sel = {select_bit_two_r, mode_configuration_r[1:0]};
    wire wr_ind = wr_go && (addr_s == `NIDRB_A_INDIRECT);
    wire rd_ind = rd_go && (addr_s == `NIDRB_A_INDIRECT);
    wire rd_succ = rd_ind && (sel == `NIDRB_S_SUCC);
    wire rd_diag = rd_go && (addr_s == `NIDRB_A_DIAG);

    function wr_sel;
        input [2:0] code;
        begin
            wr_sel = wr_ind && (sel == code);
        end
    endfunction

    // ------------------------------------------------------------
    // Hardware-reset-only registers
    // ------------------------------------------------------------
    // Soft reset deliberately leaves identity, setup and configuration intact so
    // software can restart the core without reprogramming the node.
    always @(posedge clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            probe_node_register_r <= `NIDRB_RST_PROBE;
            own_node_number_r <= `NIDRB_RST_OWN;
            mode_configuration_r <= `NIDRB_RST_CONFIG;
            speed_setup_r <= `NIDRB_RST_SETUP1;
            second_setup_r <= `NIDRB_RST_SECOND_SETUP_REGISTER;
            test_setup_r <= 8'h00;
            interrupt_mask_r <= `NIDRB_RST_MASK;
            select_bit_two_r <= 1'b0;
            subsel_spare_r <= 2'h0;
            ram_pointer_high_r <= `NIDRB_RST_PTR;
            ram_pointer_low_r <= `NIDRB_RST_PTR;
        end
        else
        begin
            if (wr_sel(`NIDRB_S_PROBE))
                probe_node_register_r <= din_r;
            if (wr_sel(`NIDRB_S_OWN))
                own_node_number_r <= din_r;
            if (wr_sel(`NIDRB_S_SETUP1))
                speed_setup_r <= din_r;
            if (wr_sel(`NIDRB_S_SUCC))
                test_setup_r <= din_r;
            if (wr_sel(`NIDRB_S_SECOND_SETUP_REGISTER))
                second_setup_r <= din_r;
            if (wr_go && addr_s == `NIDRB_A_STATUS)
                interrupt_mask_r <= din_r & `NIDRB_IRQ_BITS;
            if (wr_go && addr_s == `NIDRB_A_CONFIG)
            begin
                mode_configuration_r <= din_r;
                select_bit_two_r <= 1'b0;
            end
            else if (wr_go && addr_s == `NIDRB_A_SUBSEL)
            begin
                mode_configuration_r[1:0] <= din_r[1:0];
                select_bit_two_r <= din_r[2];
                subsel_spare_r <= {din_r[7], din_r[3]};
            end
            if (wr_go && addr_s == `NIDRB_A_PTR_HI)
                ram_pointer_high_r <= din_r;
            if (wr_go && addr_s == `NIDRB_A_PTR_LO)
                ram_pointer_low_r <= din_r;
        end
    end

    // ------------------------------------------------------------
    // RAM pointer, data register and command
    // ------------------------------------------------------------
    wire data_acc = (wr_go || rd_go) && (addr_s == `NIDRB_A_DATA);
    wire ptr_lo_wr = wr_go && (addr_s == `NIDRB_A_PTR_LO);

    always @(posedge clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ram_addr_out <= 11'h000;
            ram_rd_out <= 1'b0;
            ram_wr_out <= 1'b0;
            ram_wdata_out <= 8'h00;
            data_r <= 8'h00;
            command_strobe_out <= 1'b0;
            command_code_out <= 8'h00;
        end
        else
        begin
            ram_rd_out <= 1'b0;
            ram_wr_out <= 1'b0;
            command_strobe_out <= 1'b0;
            if (ptr_lo_wr)
            begin
                ram_addr_out <= {ram_pointer_high_r[2:0], din_r};
                ram_rd_out <= ram_pointer_high_r[`NIDRB_PTR_RDDATA];
            end
            else if (data_acc && ram_pointer_high_r[`NIDRB_PTR_AUTOINC])
            begin
                ram_addr_out <= ram_addr_out + 11'h001;
                ram_rd_out <= ram_pointer_high_r[`NIDRB_PTR_RDDATA];
            end
            if (wr_go && addr_s == `NIDRB_A_DATA)
            begin
                ram_wr_out <= 1'b1;
                ram_wdata_out <= din_r;
            end
            if (ram_rvalid_in)
                data_r <= ram_rdata_in;
            if (wr_go && addr_s == `NIDRB_A_DIAG)
            begin
                command_strobe_out <= 1'b1;
                command_code_out <= din_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers reset by hardware or soft reset
    // ------------------------------------------------------------
    // Soft reset is a level held in the configuration register, so these bits
    // stay at their reset values for as long as software holds it.
    wire probe_hit = node_seen_in && (node_seen_id_in == probe_node_register_r)
        && (node_seen_id_in != successor_node_number_r);
    reg [7:0] diag_nxt;

    always @*
    begin
        diag_nxt = diag_r;
        if (rd_diag)
            diag_nxt = diag_r & 8'h0a;
        if (por_clear_flags_in)
            diag_nxt[`NIDRB_DG_EXCESS_NAK_FLAG] = 1'b0;
        if (rd_succ)
            diag_nxt[`NIDRB_DG_NEWSUCC] = 1'b0;
        // Events win over a clear in the same cycle so that none is lost.
        if (myrecon_event_in)
            diag_nxt[`NIDRB_DG_MYRECON] = 1'b1;
        if (duplicate_node_flag_in)
            diag_nxt[`NIDRB_DG_DUP] = 1'b1;
        if (rcvact_event_in)
            diag_nxt[`NIDRB_DG_RCVACT] = 1'b1;
        if (token_event_in)
            diag_nxt[`NIDRB_DG_TOKEN] = 1'b1;
        if (excess_nak_event_in)
            diag_nxt[`NIDRB_DG_EXCESS_NAK_FLAG] = 1'b1;
        if (probe_hit)
            diag_nxt[`NIDRB_DG_PROBE] = 1'b1;
        if (succ_update_in)
            diag_nxt[`NIDRB_DG_NEWSUCC] = 1'b1;
        diag_nxt[0] = 1'b0;
    end

    always @(posedge clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            successor_node_number_r <= `NIDRB_RST_SUCC;
            diag_r <= 8'h00;
            por_r <= 1'b1;
            recon_r <= 1'b0;
            ri_r <= 1'b1;
            ta_r <= 1'b1;
            tma_r <= 1'b0;
        end
        else if (soft_rst)
        begin
            successor_node_number_r <= `NIDRB_RST_SUCC;
            diag_r <= 8'h00;
            por_r <= 1'b1;
            recon_r <= 1'b0;
            ri_r <= 1'b1;
            ta_r <= 1'b1;
            tma_r <= 1'b0;
        end
        else
        begin
            if (succ_update_in)
                successor_node_number_r <= succ_value_in;
            diag_r <= diag_nxt;
            if (wr_sel(`NIDRB_S_OWN) && din_r == 8'h00)
                por_r <= 1'b1;
            else if (clear_flags_in)
                por_r <= 1'b0;
            if (recon_event_in)
                recon_r <= 1'b1;
            else if (clear_flags_in)
                recon_r <= 1'b0;
            ri_r <= ri_in;
            ta_r <= ta_in;
            tma_r <= tma_in;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Bits 6 and 5 carry nothing; extended timeout is only in configuration.
    wire [7:0] main_status = {ri_r, 2'b00, por_r, 1'b0, recon_r, tma_r, ta_r};
    reg [7:0] rd_nxt;

    always @*
    begin
        rd_nxt = 8'h00;
        case (addr_s)
            `NIDRB_A_STATUS:
                rd_nxt = mode_configuration_r[`NIDRB_CFG_CHAIN] ?
                    chain_status_in : main_status;
            `NIDRB_A_DIAG: rd_nxt = diag_r;
            `NIDRB_A_PTR_HI: rd_nxt = ram_pointer_high_r;
            `NIDRB_A_PTR_LO: rd_nxt = ram_pointer_low_r;
            `NIDRB_A_DATA: rd_nxt = data_r;
            `NIDRB_A_SUBSEL: rd_nxt = {subsel_spare_r[1], 3'b000, subsel_spare_r[0], sel};
            `NIDRB_A_CONFIG: rd_nxt = mode_configuration_r;
            default:
            begin
                case (sel)
                    `NIDRB_S_PROBE: rd_nxt = probe_node_register_r;
                    `NIDRB_S_OWN: rd_nxt = own_node_number_r;
                    `NIDRB_S_SETUP1: rd_nxt = speed_setup_r;
                    `NIDRB_S_SUCC: rd_nxt = successor_node_number_r;
                    `NIDRB_S_SECOND_SETUP_REGISTER: rd_nxt = second_setup_r;
                    default: rd_nxt = 8'h00;
                endcase
            end
        endcase
    end

    always @(posedge clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
            data_out <= 8'h00;
        else if (rd_go)
            data_out <= rd_nxt;
    end

    // ------------------------------------------------------------
    // Core control and interrupt
    // ------------------------------------------------------------
    assign core_awake_out = (own_node_number_r != 8'h00);
    assign transmit_join_enable_out = core_awake_out
        && mode_configuration_r[`NIDRB_CFG_TRANSMIT_JOIN_ENABLE];
    assign receiver_on_out = core_awake_out;
    assign soft_reset_out = soft_rst;
    assign chain_enable_out = mode_configuration_r[`NIDRB_CFG_CHAIN];
    assign ext_timeout_out = {mode_configuration_r[`NIDRB_CFG_ET1],
        mode_configuration_r[`NIDRB_CFG_ET2]};
    assign backplane_out = mode_configuration_r[`NIDRB_CFG_BACKPLANE];
    assign speed_setup_out = speed_setup_r;
    assign second_setup_out = second_setup_r;
    assign test_setup_out = test_setup_r;
    assign interrupt_out = |(interrupt_mask_r & {ri_r, 3'b000,
        diag_r[`NIDRB_DG_EXCESS_NAK_FLAG], recon_r, diag_r[`NIDRB_DG_NEWSUCC], ta_r});

endmodule

// ### inc/nidrb_consts.vh
`ifndef NIDRB_CONSTS_VH
`define NIDRB_CONSTS_VH

// ------------------------------------------------------------
// Direct register addresses
// ------------------------------------------------------------
`define NIDRB_A_STATUS 3'h0
`define NIDRB_A_DIAG 3'h1
`define NIDRB_A_PTR_HI 3'h2
`define NIDRB_A_PTR_LO 3'h3
`define NIDRB_A_DATA 3'h4
`define NIDRB_A_SUBSEL 3'h5
`define NIDRB_A_CONFIG 3'h6
`define NIDRB_A_INDIRECT 3'h7

// ------------------------------------------------------------
// Indirect selections at address seven
// ------------------------------------------------------------
`define NIDRB_S_PROBE 3'h0
`define NIDRB_S_OWN 3'h1
`define NIDRB_S_SETUP1 3'h2
`define NIDRB_S_SUCC 3'h3
`define NIDRB_S_SECOND_SETUP_REGISTER 3'h4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define NIDRB_RST_PROBE 8'h00
`define NIDRB_RST_OWN 8'h00
`define NIDRB_RST_SUCC 8'h00
`define NIDRB_RST_CONFIG 8'h18
`define NIDRB_RST_SETUP1 8'h00
`define NIDRB_RST_SECOND_SETUP_REGISTER 8'h00
`define NIDRB_RST_MASK 8'h00
`define NIDRB_RST_SUBSEL 8'h00
`define NIDRB_RST_PTR 8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define NIDRB_CFG_RESET 7
`define NIDRB_CFG_CHAIN 6
`define NIDRB_CFG_TRANSMIT_JOIN_ENABLE 5
`define NIDRB_CFG_ET1 4
`define NIDRB_CFG_ET2 3
`define NIDRB_CFG_BACKPLANE 2
`define NIDRB_PTR_RDDATA 7
`define NIDRB_PTR_AUTOINC 6
`define NIDRB_ST_RI 7
`define NIDRB_ST_POR 4
`define NIDRB_ST_RECON 2
`define NIDRB_ST_TMA 1
`define NIDRB_ST_TA 0
`define NIDRB_DG_MYRECON 7
`define NIDRB_DG_DUP 6
`define NIDRB_DG_RCVACT 5
`define NIDRB_DG_TOKEN 4
`define NIDRB_DG_EXCESS_NAK_FLAG 3
`define NIDRB_DG_PROBE 2
`define NIDRB_DG_NEWSUCC 1
`define NIDRB_IRQ_BITS 8'h8f

`endif

// ### tb/nidrb_host_model.sv
`timescale 1ns/10ps
module nidrb_host_model
(
    input wire clk_in,
    input wire [7:0] rdata_in,
    output reg cs_n_out,
    output reg rd_n_out,
    output reg wr_n_out,
    output reg [2:0] addr_out,
    output reg [7:0] data_out
);
    // ----------------------------------------------------------------
    // Host bus cycles
    // ----------------------------------------------------------------
    initial
    begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        addr_out = 3'h0;
        data_out = 8'h00;
    end
    // Address and data settle three clocks ahead, strobes stay low six clocks so the
    // synchronised edge detect sees each one once, and idle gaps are three clocks.
    task wr(input [2:0] a, input [7:0] d);
        addr_out = a;
        data_out = d;
        repeat (3) @(posedge clk_in);
        #1 cs_n_out = 1'b0;
        wr_n_out = 1'b0;
        repeat (6) @(posedge clk_in);
        #1 cs_n_out = 1'b1;
        wr_n_out = 1'b1;
        // Released data lines show the inverse so stale values never match by luck.
        data_out = ~d;
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task rd(input [2:0] a, output [7:0] q);
        addr_out = a;
        repeat (3) @(posedge clk_in);
        #1 cs_n_out = 1'b0;
        rd_n_out = 1'b0;
        repeat (6) @(posedge clk_in);
        q = rdata_in;
        #1 cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
    endtask
endmodule

// ### tb/nidrb_sva.sv
`timescale 1ns/10ps
module nidrb_sva
(
    input wire clk_in,
    input wire nrst_in,
    input wire cs_n_in,
    input wire rd_n_in,
    input wire wr_n_in,
    input wire [2:0] addr_in,
    input wire [7:0] data_in,
    input wire data_oe_out,
    input wire command_strobe_out,
    input wire [7:0] command_code_out,
    input wire [10:0] ram_addr_out,
    input wire ram_rd_out,
    input wire core_awake_out,
    input wire transmit_join_enable_out,
    input wire receiver_on_out,
    input wire [1:0] ext_timeout_out,
    input wire [7:0] speed_setup_out,
    input wire interrupt_out
);
    // ----------------------------------------------------------------
    // Port checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_cmd_after_wr: assert property ($fell(wr_n_in) && !cs_n_in && addr_in == 3'h1
        |-> ##[2:6] command_strobe_out)
        else $error("command write gave no strobe");
    a_cmd_code_src: assert property (command_strobe_out
        |-> command_code_out == data_in && !$past(wr_n_in, 3))
        else $error("command strobe without matching write");
    a_cmd_one_shot: assert property (command_strobe_out |=> !command_strobe_out)
        else $error("command strobe longer than one cycle");
    a_ptr_low_load: assert property ($fell(wr_n_in) && !cs_n_in && addr_in == 3'h3
        |-> ##[2:6] ram_addr_out[7:0] == data_in)
        else $error("low pointer write not loaded");
    a_ram_rd_single: assert property (ram_rd_out |=> !ram_rd_out)
        else $error("ram read request repeated");
    a_oe_on_read: assert property ((!rd_n_in && !cs_n_in) [*4] |-> data_oe_out)
        else $error("read strobe did not enable data");
    a_oe_needs_read: assert property (data_oe_out
        |-> !$past(rd_n_in, 1) || !$past(rd_n_in, 2) || !$past(rd_n_in, 3))
        else $error("data enabled without read");
    a_awake_by_write: assert property ($changed(core_awake_out)
        |-> !$past(wr_n_in, 3))
        else $error("core wake changed without write");
    a_join_needs_awake: assert property (transmit_join_enable_out
        |-> core_awake_out && receiver_on_out)
        else $error("join enabled while asleep");
    a_asleep_quiet: assert property (!core_awake_out
        |-> !transmit_join_enable_out && !receiver_on_out)
        else $error("sleeping core still active");
    a_reset_values: assert property ($rose(nrst_in)
        |-> ext_timeout_out == 2'b11 && speed_setup_out == 8'h00 && !core_awake_out)
        else $error("wrong values after reset");
    c_cmd: cover property (command_strobe_out);
    c_ram_rd: cover property (ram_rd_out);
    c_irq: cover property (interrupt_out);
    c_join: cover property (transmit_join_enable_out);
endmodule

bind nidrb_register_bank nidrb_sva chk
(
    .clk_in, .nrst_in, .cs_n_in, .rd_n_in, .wr_n_in, .addr_in, .data_in, .data_oe_out,
    .command_strobe_out, .command_code_out, .ram_addr_out, .ram_rd_out, .core_awake_out,
    .transmit_join_enable_out, .receiver_on_out, .ext_timeout_out, .speed_setup_out,
    .interrupt_out
);

// ### tb/tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    wire cs_n_in, rd_n_in, wr_n_in, data_oe_out, command_strobe_out, ram_rd_out;
    wire core_awake_out, transmit_join_enable_out, receiver_on_out, soft_reset_out;
    wire chain_enable_out, interrupt_out, backplane_out, ram_wr_out;
    wire [7:0] second_setup_out, test_setup_out, ram_wdata_out;
    wire [2:0] addr_in;
    wire [7:0] data_in, data_out, command_code_out, speed_setup_out;
    wire [10:0] ram_addr_out;
    wire [1:0] ext_timeout_out;
    logic [9:0] ev = 10'h000;
    logic [7:0] succ_value_in = 8'h00;
    logic [7:0] node_seen_id_in = 8'h00;
    logic ri_in = 1'b1;
    logic ta_in = 1'b1;
    logic ram_rvalid_in = 1'b0;
    logic [7:0] q;
    int n_errors = 0;
    int num_checks = 0;
    int n_rd = 0;
    int n_wr = 0;
    logic [31:0] rows [0:11] = '{32'h06180618, 32'h075a075a, 32'h06190619, 32'h073c073c,
        32'h061a061a, 32'h07a507a5, 32'h05040504, 32'h07770777,
        32'h061a0502, 32'h05010619, 32'h02070207, 32'h035c035c};

    nidrb_register_bank uut
    (
        .clk_in, .nrst_in, .cs_n_in, .rd_n_in, .wr_n_in, .addr_in, .data_in, .data_out,
        .data_oe_out, .succ_update_in(ev[0]), .succ_value_in, .node_seen_in(ev[1]),
        .node_seen_id_in, .myrecon_event_in(ev[2]), .duplicate_node_flag_in(ev[3]),
        .rcvact_event_in(ev[4]), .token_event_in(ev[5]), .excess_nak_event_in(ev[6]),
        .recon_event_in(ev[7]), .clear_flags_in(ev[8]), .por_clear_flags_in(ev[9]),
        .ri_in, .ta_in, .tma_in(1'b0), .chain_status_in(8'h6b), .ram_rdata_in(8'hc6),
        .ram_rvalid_in, .command_strobe_out, .command_code_out, .ram_addr_out, .ram_rd_out,
        .ram_wr_out, .ram_wdata_out, .core_awake_out, .transmit_join_enable_out,
        .receiver_on_out, .soft_reset_out, .chain_enable_out, .ext_timeout_out,
        .backplane_out, .speed_setup_out, .second_setup_out, .test_setup_out,
        .interrupt_out
    );
    nidrb_host_model host
    (
        .clk_in, .rdata_in(data_out), .cs_n_out(cs_n_in), .rd_n_out(rd_n_in),
        .wr_n_out(wr_n_in), .addr_out(addr_in), .data_out(data_in)
    );

    // ----------------------------------------------------------------
    // Clock, memory side and helpers
    // ----------------------------------------------------------------
    always #5 clk_in = ~clk_in;
    // The memory answers one cycle after each request; counting them catches extra reads.
    always @(posedge clk_in)
    begin
        ram_rvalid_in <= ram_rd_out;
        if (ram_rd_out) n_rd <= n_rd + 1;
        if (ram_wr_out) n_wr <= n_wr + 1;
    end
    task w(input [2:0] a, input [7:0] d);
        host.wr(a, d);
    endtask
    task rc(input [2:0] a, input [7:0] m, input [7:0] e);
        host.rd(a, q);
        `CHK($sformatf("read %0h", a), e, q & m)
    endtask
    task pulse(input [9:0] v);
        @(posedge clk_in);
        #1 ev = v;
        @(posedge clk_in);
        #1 ev = 10'h000;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task end_of_test;
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // About seventy bus cycles of twelve clocks each; the limit leaves a wide margin.
    initial
    begin
        #200000;
        n_errors++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        `CHK("awake", 1'b0, core_awake_out)
        `CHK("irq", 1'b0, interrupt_out)
        rc(3'h0, 8'h9f, 8'h91);
        rc(3'h1, 8'hfe, 8'h00);
        for (int i = 0; i < 12; i++)
        begin
            w(rows[i][26:24], rows[i][23:16]);
            rc(rows[i][10:8], 8'hff, rows[i][7:0]);
        end
        `CHK("setup", 8'ha5, speed_setup_out)
        `CHK("second_setup_register", 8'h77, second_setup_out)
        `CHK("awake", 1'b1, core_awake_out)
        `CHK("rx", 1'b1, receiver_on_out)
        `CHK("join", 1'b0, transmit_join_enable_out)
        w(3'h6, 8'h39);
        `CHK("join", 1'b1, transmit_join_enable_out)
        w(3'h6, 8'h19);
        pulse(10'h0fc);
        rc(3'h1, 8'hfe, 8'hf8);
        rc(3'h1, 8'hfe, 8'h08);
        rc(3'h0, 8'h9f, 8'h95);
        pulse(10'h100);
        rc(3'h0, 8'h9f, 8'h81);
        pulse(10'h200);
        rc(3'h1, 8'hfe, 8'h00);
        w(3'h0, 8'h02);
        succ_value_in = 8'h42;
        pulse(10'h001);
        `CHK("irq", 1'b1, interrupt_out)
        rc(3'h1, 8'h02, 8'h02);
        rc(3'h1, 8'h02, 8'h02);
        w(3'h6, 8'h1b);
        rc(3'h7, 8'hff, 8'h42);
        `CHK("irq", 1'b0, interrupt_out)
        w(3'h7, 8'h5a);
        `CHK("test", 8'h5a, test_setup_out)
        rc(3'h7, 8'hff, 8'h42);
        w(3'h0, 8'h01);
        `CHK("irq", 1'b1, interrupt_out)
        ta_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        `CHK("irq", 1'b0, interrupt_out)
        ta_in = 1'b1;
        w(3'h0, 8'h00);
        w(3'h6, 8'h18);
        w(3'h7, 8'h33);
        node_seen_id_in = 8'h33;
        pulse(10'h002);
        rc(3'h1, 8'h04, 8'h04);
        w(3'h7, 8'h42);
        node_seen_id_in = 8'h42;
        pulse(10'h042);
        rc(3'h1, 8'h04, 8'h00);
        w(3'h6, 8'h98);
        `CHK("soft", 1'b1, soft_reset_out)
        w(3'h6, 8'h18);
        rc(3'h7, 8'hff, 8'h42);
        w(3'h6, 8'h1b);
        rc(3'h7, 8'hff, 8'h00);
        w(3'h6, 8'h19);
        rc(3'h7, 8'hff, 8'h3c);
        w(3'h6, 8'h1a);
        rc(3'h7, 8'hff, 8'ha5);
        rc(3'h0, 8'h9f, 8'h91);
        rc(3'h1, 8'hfe, 8'h00);
        w(3'h6, 8'h4c);
        `CHK("chain", 1'b1, chain_enable_out)
        `CHK("backplane", 1'b1, backplane_out)
        `CHK("timeout", 2'b01, ext_timeout_out)
        rc(3'h0, 8'hff, 8'h6b);
        w(3'h6, 8'h18);
        w(3'h1, 8'h0c);
        `CHK("command", 8'h0c, command_code_out)
        w(3'h2, 8'h81);
        w(3'h3, 8'h23);
        `CHK("pointer", 11'h123, ram_addr_out)
        rc(3'h4, 8'hff, 8'hc6);
        w(3'h4, 8'h5e);
        `CHK("wdata", 8'h5e, ram_wdata_out)
        `CHK("ram writes", 1, n_wr)
        w(3'h2, 8'hc1);
        w(3'h3, 8'h40);
        rc(3'h4, 8'hff, 8'hc6);
        `CHK("pointer", 11'h141, ram_addr_out)
        `CHK("ram reads", 3, n_rd)
        nrst_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        `CHK("irq", 1'b0, interrupt_out)
        `CHK("setup", 8'h00, speed_setup_out)
        `CHK("awake", 1'b0, core_awake_out)
        rc(3'h6, 8'hff, 8'h18);
        rc(3'h7, 8'hff, 8'h00);
        end_of_test();
    end
endmodule
